// ### rtl/ucrm_pkg.sv
/*
 Shared constants and carrier types of the compatible UART register map.
 Assumes an 8-bit host data bus and three address lines.
*/
package ucrm_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [2:0] ADR_HOLD = 3'h0;
    localparam logic [2:0] ADR_IEN = 3'h1;
    localparam logic [2:0] ADR_ISTS = 3'h2;
    localparam logic [2:0] ADR_LCTL = 3'h3;
    localparam logic [2:0] ADR_MCTL = 3'h4;
    localparam logic [2:0] ADR_LSTS = 3'h5;
    localparam logic [2:0] ADR_MSTS = 3'h6;
    localparam logic [2:0] ADR_SPAD = 3'h7;

    // ==========================================================
    // Values, masks and field positions
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] LCTL_ENH_KEY = 8'hbf;
    localparam logic [7:0] IEN_ENH_MASK = 8'hf0;
    localparam logic [7:0] FCTL_ENH_MASK = 8'h38;
    localparam logic [7:0] FCTL_ZERO_MASK = 8'h06;
    localparam logic [7:0] MCTL_ENH_MASK = 8'he0;
    localparam logic [7:0] NO_MASK = 8'h00;
    localparam logic [7:0] OPTS_ZERO_MASK = 8'h0f;
    localparam logic [7:0] EMS_ZERO_MASK = 8'h30;
    localparam int LCTL_DIV = 7;
    localparam int FCTL_FIFO_EN = 0;
    localparam int FCTL_RX_RST = 1;
    localparam int FCTL_TX_RST = 2;
    localparam int MCTL_DTR = 0;
    localparam int MCTL_RTS = 1;
    localparam int MCTL_OUT1 = 2;
    localparam int MCTL_IRQ_EN = 3;
    localparam int MCTL_LOOP = 4;
    localparam int MODEM_CNT = 4;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ucrm_bus_t;

    typedef struct packed {
        logic [7:0] ien;
        logic [7:0] fctl;
        logic [7:0] lctl;
        logic [7:0] mctl;
        logic [7:0] opts;
        logic [7:0] ems;
    } ucrm_ctl_t;

    typedef struct packed {
        logic [3:0] int_src;
        logic xoff_int;
        logic flow_int;
        logic [7:0] lsts;
        logic [7:0] level;
    } ucrm_sts_t;

endpackage

// ### rtl/ucrm_mask_reg.sv
/*
 One 8-bit control register whose enhanced bits are gated by the
 enhanced-function enable and whose fixed-zero bits never store.
 Assumes a one-cycle write strobe on the system clock.
*/
`timescale 1ns/10ps
module ucrm_mask_reg #(
    parameter logic [7:0] ENH_MASK = 8'h00,
    parameter logic [7:0] ZERO_MASK = 8'h00
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Write side
    input wire logic we_i,
    input wire logic enh_en_i,
    input wire logic [7:0] wdata_i,
    // Effective value
    output logic [7:0] q_o
);
    import ucrm_pkg::*;

    logic [7:0] q_ff;
    logic [7:0] nxt_q;
    logic [7:0] wmask;

    // Enhanced bits stay inactive and hold still while the enable is low.
    assign wmask = enh_en_i ? ~ZERO_MASK : ~(ZERO_MASK | ENH_MASK);
    assign nxt_q = (wdata_i & wmask) | (q_ff & ~wmask & ~ZERO_MASK);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_ff <= REG_RST;
        end else if (ce_i && we_i) begin
            q_ff <= nxt_q;
        end
    end

    assign q_o = enh_en_i ? q_ff : (q_ff & ~ENH_MASK);

endmodule

// ### rtl/ucrm_delta.sv
/*
 Change flags for the modem inputs: a flag sets on any change of its
 level and clears on a status read; a change in the clearing cycle wins.
 Assumes levels synchronous to the system clock.
*/
`timescale 1ns/10ps
module ucrm_delta (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Levels and clear
    input wire logic [ucrm_pkg::MODEM_CNT-1:0] lvl_i,
    input wire logic clr_i,
    // Sticky change flags
    output logic [ucrm_pkg::MODEM_CNT-1:0] flag_o
);
    import ucrm_pkg::*;

    logic armed_ff;

    // The first sample after reset only primes the history.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed_ff <= 1'b0;
        end else if (ce_i) begin
            armed_ff <= 1'b1;
        end
    end

    for (genvar i = 0; i < MODEM_CNT; i++) begin : g_bit
        logic prev_ff;
        logic flag_ff;
        always_ff @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
                prev_ff <= 1'b0;
                flag_ff <= 1'b0;
            end else if (ce_i) begin
                prev_ff <= lvl_i[i];
                if (armed_ff && (prev_ff != lvl_i[i])) begin
                    flag_ff <= 1'b1;
                end else if (clr_i) begin
                    flag_ff <= 1'b0;
                end
            end
        end
        assign flag_o[i] = flag_ff;
    end

endmodule

// ### rtl/ucrm_regmap.sv
/*
 Compatible register set of a single-channel UART: host decode, control
 registers, status read-back and the access side effects.
 Assumes the divisor and enhanced banks sit beside this block, answer
 when foreign_o is high, and deliver the enhanced enable and the
 scratch-pad swap bit as levels. Host strobes are synchronous levels;
 each rising edge of chip select with a strobe is one access.
// Behaviour
// - Enhanced fields inactive, read zero unless enabled.
// - Interrupt enable register layout at address one.
// - Interrupt status read layout at address two.
// - FIFO control write layout at address two.
// - Line control register layout at address three.
// - Modem control register layout at address four.
// - Line status read layout at address five.
// - Modem status: change flags and input levels.
// - Address seven: scratch pad or mode/level by swap.
// - Enhanced mode select register layout, bits 5:4 zero.
*/
`timescale 1ns/10ps
module ucrm_regmap (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Host bus
    input wire ucrm_pkg::ucrm_bus_t bus_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic foreign_o,
    // Enhanced bank state
    input wire logic enh_en_i,
    input wire logic swap_spad_i,
    // Data path
    input wire logic [7:0] rx_data_i,
    output logic rx_pop_o,
    output logic [7:0] tx_data_o,
    output logic tx_push_o,
    output logic rx_fifo_rst_o,
    output logic tx_fifo_rst_o,
    // Engine status
    input wire ucrm_pkg::ucrm_sts_t sts_i,
    output logic lsts_read_o,
    output logic ists_read_o,
    // Modem lines, asserted high
    input wire logic [ucrm_pkg::MODEM_CNT-1:0] modem_in_i,
    output logic dtr_o,
    output logic rts_o,
    output logic out1_o,
    output logic irq_en_o,
    // Control registers
    output ucrm_pkg::ucrm_ctl_t ctl_o
);
    import ucrm_pkg::*;

    // ==========================================================
    // Access decode
    logic rd_prev_ff;
    logic wr_prev_ff;
    logic acc_rd;
    logic acc_wr;
    logic own;
    logic rd_go;
    logic wr_go;
    logic [2:0] addr;
    logic [7:0] wdata;

    assign addr = bus_i.addr;
    assign wdata = bus_i.wdata;
    assign acc_rd = bus_i.cs && bus_i.rd;
    assign acc_wr = bus_i.cs && bus_i.wr;

    // Divisor access and the enhanced key hand addresses to the other banks.
    always_comb begin
        own = 1'b1;
        if ((ctl_o.lctl == LCTL_ENH_KEY) && (addr != ADR_LCTL)) begin
            own = 1'b0;
        end else if (ctl_o.lctl[LCTL_DIV]) begin
            if ((addr == ADR_HOLD) || (addr == ADR_IEN)) begin
                own = 1'b0;
            end else if ((addr == ADR_ISTS) && enh_en_i) begin
                own = 1'b0;
            end
        end
    end

    assign foreign_o = (acc_rd || acc_wr) && !own;
    assign rd_go = ce_i && acc_rd && !rd_prev_ff && own;
    assign wr_go = ce_i && acc_wr && !wr_prev_ff && own;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b0;
        end else if (ce_i) begin
            rd_prev_ff <= acc_rd;
            wr_prev_ff <= acc_wr;
        end
    end

    // ==========================================================
    // Control registers
    logic [7:0] lctl_ff;
    logic [7:0] spad_ff;
    logic [7:0] ems_ff;
    logic [7:0] ien_q;
    logic [7:0] fctl_q;
    logic [7:0] mctl_q;
    logic [7:0] opts_q;

    ucrm_mask_reg #(
        .ENH_MASK (IEN_ENH_MASK),
        .ZERO_MASK (NO_MASK)
    ) u_ien (
        .clk_sys_i (clk_sys_i),
        .rstn_i (rstn_i),
        .ce_i (ce_i),
        .we_i (wr_go && (addr == ADR_IEN)),
        .enh_en_i (enh_en_i),
        .wdata_i (wdata),
        .q_o (ien_q)
    );

    ucrm_mask_reg #(
        .ENH_MASK (FCTL_ENH_MASK),
        .ZERO_MASK (FCTL_ZERO_MASK)
    ) u_fctl (
        .clk_sys_i (clk_sys_i),
        .rstn_i (rstn_i),
        .ce_i (ce_i),
        .we_i (wr_go && (addr == ADR_ISTS)),
        .enh_en_i (enh_en_i),
        .wdata_i (wdata),
        .q_o (fctl_q)
    );

    ucrm_mask_reg #(
        .ENH_MASK (MCTL_ENH_MASK),
        .ZERO_MASK (NO_MASK)
    ) u_mctl (
        .clk_sys_i (clk_sys_i),
        .rstn_i (rstn_i),
        .ce_i (ce_i),
        .we_i (wr_go && (addr == ADR_MCTL)),
        .enh_en_i (enh_en_i),
        .wdata_i (wdata),
        .q_o (mctl_q)
    );

    ucrm_mask_reg #(
        .ENH_MASK (NO_MASK),
        .ZERO_MASK (OPTS_ZERO_MASK)
    ) u_opts (
        .clk_sys_i (clk_sys_i),
        .rstn_i (rstn_i),
        .ce_i (ce_i),
        .we_i (wr_go && (addr == ADR_MSTS)),
        .enh_en_i (enh_en_i),
        .wdata_i (wdata),
        .q_o (opts_q)
    );

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lctl_ff <= REG_RST;
        end else if (wr_go && (addr == ADR_LCTL)) begin
            lctl_ff <= wdata;
        end
    end

    // The swap bit steers writes at address seven.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            spad_ff <= REG_RST;
            ems_ff <= REG_RST;
        end else if (wr_go && (addr == ADR_SPAD)) begin
            if (swap_spad_i) begin
                ems_ff <= wdata & ~EMS_ZERO_MASK;
            end else begin
                spad_ff <= wdata;
            end
        end
    end

    assign ctl_o.ien = ien_q;
    assign ctl_o.fctl = fctl_q;
    assign ctl_o.lctl = lctl_ff;
    assign ctl_o.mctl = mctl_q;
    assign ctl_o.opts = opts_q;
    assign ctl_o.ems = ems_ff;

    // ==========================================================
    // Modem lines and loopback
    logic [MODEM_CNT-1:0] lvl;
    logic [MODEM_CNT-1:0] delta;
    logic loop;
    logic msts_clr;

    assign loop = mctl_q[MCTL_LOOP];

    // In loopback the outputs feed the status inputs and the pins go idle.
    assign lvl = loop ? {mctl_q[MCTL_IRQ_EN], mctl_q[MCTL_OUT1],
                         mctl_q[MCTL_DTR], mctl_q[MCTL_RTS]} : modem_in_i;
    assign dtr_o = mctl_q[MCTL_DTR] && !loop;
    assign rts_o = mctl_q[MCTL_RTS] && !loop;
    assign out1_o = mctl_q[MCTL_OUT1] && !loop;
    assign irq_en_o = mctl_q[MCTL_IRQ_EN] && !loop;
    assign msts_clr = rd_go && (addr == ADR_MSTS);

    ucrm_delta u_delta (
        .clk_sys_i (clk_sys_i),
        .rstn_i (rstn_i),
        .ce_i (ce_i),
        .lvl_i (lvl),
        .clr_i (msts_clr),
        .flag_o (delta)
    );

    // ==========================================================
    // Read mux
    logic [7:0] ists;
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;
    logic oe_ff;

    assign ists = {{2{fctl_q[FCTL_FIFO_EN]}}, sts_i.flow_int && enh_en_i,
                   sts_i.xoff_int && enh_en_i, sts_i.int_src};

    always_comb begin
        case (addr)
            ADR_HOLD: nxt_rdata = rx_data_i;
            ADR_IEN: nxt_rdata = ien_q;
            ADR_ISTS: nxt_rdata = ists;
            ADR_LCTL: nxt_rdata = lctl_ff;
            ADR_MCTL: nxt_rdata = mctl_q;
            ADR_LSTS: nxt_rdata = sts_i.lsts;
            ADR_MSTS: nxt_rdata = {lvl, delta};
            ADR_SPAD: nxt_rdata = swap_spad_i ? sts_i.level : spad_ff;
            default: nxt_rdata = REG_RST;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= REG_RST;
        end else if (rd_go) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // The data bus is driven from the captured byte until the strobe drops.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_ff <= 1'b0;
        end else if (ce_i) begin
            oe_ff <= rd_go || (oe_ff && acc_rd);
        end
    end

    assign data_o = rdata_ff;
    assign data_oe_o = oe_ff;

    // ==========================================================
    // Access side effects
    logic [7:0] tx_data_ff;
    logic tx_push_ff;
    logic rx_pop_ff;
    logic rx_rst_ff;
    logic tx_rst_ff;
    logic lsts_rd_ff;
    logic ists_rd_ff;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_data_ff <= REG_RST;
        end else if (wr_go && (addr == ADR_HOLD)) begin
            tx_data_ff <= wdata;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_push_ff <= 1'b0;
            rx_pop_ff <= 1'b0;
            lsts_rd_ff <= 1'b0;
            ists_rd_ff <= 1'b0;
        end else if (ce_i) begin
            tx_push_ff <= wr_go && (addr == ADR_HOLD);
            rx_pop_ff <= rd_go && (addr == ADR_HOLD);
            lsts_rd_ff <= rd_go && (addr == ADR_LSTS);
            ists_rd_ff <= rd_go && (addr == ADR_ISTS);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_rst_ff <= 1'b0;
            tx_rst_ff <= 1'b0;
        end else if (ce_i) begin
            rx_rst_ff <= wr_go && (addr == ADR_ISTS) && wdata[FCTL_RX_RST];
            tx_rst_ff <= wr_go && (addr == ADR_ISTS) && wdata[FCTL_TX_RST];
        end
    end

    assign tx_data_o = tx_data_ff;
    assign tx_push_o = tx_push_ff;
    assign rx_pop_o = rx_pop_ff;
    assign rx_fifo_rst_o = rx_rst_ff;
    assign tx_fifo_rst_o = tx_rst_ff;
    assign lsts_read_o = lsts_rd_ff;
    assign ists_read_o = ists_rd_ff;

    // ==========================================================
    // Checks
    enh_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_go && !enh_en_i && (addr == ADR_IEN)) |=> (data_o[7:4] == 4'h0))
        else $error("enhanced enable bits visible while disabled");

    thr_push_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_go && (addr == ADR_HOLD)) |=> (tx_push_o && (tx_data_o == $past(wdata))))
        else $error("transmit byte not pushed");

    ien_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_go && enh_en_i && (addr == ADR_IEN)) |=> (ctl_o.ien == $past(wdata)))
        else $error("interrupt enable not stored");

    ists_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_go && (addr == ADR_ISTS)) |=> (ists_read_o
            && (data_o[7:6] == {2{$past(fctl_q[FCTL_FIFO_EN])}})
            && (data_o[3:0] == $past(sts_i.int_src))))
        else $error("interrupt status read wrong");

    fifo_rst_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_go && (addr == ADR_ISTS)) |=> ((rx_fifo_rst_o == $past(wdata[FCTL_RX_RST]))
            && (tx_fifo_rst_o == $past(wdata[FCTL_TX_RST])) && !ctl_o.fctl[FCTL_RX_RST]))
        else $error("fifo reset pulse wrong");

    lctl_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_go && (addr == ADR_LCTL)) |=> (ctl_o.lctl == $past(wdata)))
        else $error("line control not stored");

    loop_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        ctl_o.mctl[MCTL_LOOP] |-> (!dtr_o && !rts_o && (lvl[0] == ctl_o.mctl[MCTL_RTS])))
        else $error("loopback modem lines wrong");

    lsts_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_go && (addr == ADR_LSTS)) |=> (lsts_read_o && (data_o == $past(sts_i.lsts))))
        else $error("line status read wrong");

    msts_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_go && (addr == ADR_MSTS)) |=> (data_o == {$past(lvl), $past(delta)}))
        else $error("modem status read wrong");

    opts_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_go && (addr == ADR_MSTS)) |=> (ctl_o.opts == {$past(wdata[7:4]), 4'h0}))
        else $error("modem options not stored");

    level_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_go && swap_spad_i && (addr == ADR_SPAD)) |=> (data_o == $past(sts_i.level)))
        else $error("fifo level not returned");

    ems_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_go && swap_spad_i && (addr == ADR_SPAD)) |=>
            (ctl_o.ems == {$past(wdata[7:6]), 2'h0, $past(wdata[3:0])}))
        else $error("mode select not stored");

endmodule

// ### verif/ucrm_host_model.sv
/*
 Host processor model: one read or write access per call on the
 parallel register bus of the register map.
 Assumes its task is called at a falling edge of the system clock.
*/
`timescale 1ns/10ps
module ucrm_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Bus to the register map
    output ucrm_pkg::ucrm_bus_t bus_o,
    input wire logic [7:0] data_i,
    input wire logic data_oe_i
);
    import ucrm_pkg::*;

    // ==========================================================
    // Access task
    initial bus_o = '0;

    // Strobes rise after a falling edge and stand across two rising edges.
    // They then stay low for a full cycle, so the next call is a fresh access.
    // Released data lines show the inverse of the last value, not a stale copy.
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic oe);
        @(negedge clk_sys_i);
        bus_o.cs = 1'b1;
        bus_o.rd = ~wr;
        bus_o.wr = wr;
        bus_o.addr = a;
        bus_o.wdata = d;
        repeat (2) @(negedge clk_sys_i);
        q = data_i;
        oe = data_oe_i;
        bus_o.cs = 1'b0;
        bus_o.rd = 1'b0;
        bus_o.wr = 1'b0;
        bus_o.wdata = ~d;
        @(negedge clk_sys_i);
    endtask
endmodule

// ### verif/uart_compatible_register_map_tb_top.sv
/*
 Self-checking bench of the compatible register map: table-driven host
 accesses, then modem status, data path, FIFO control, options, mode
 select, refused accesses, clock enable and reset by hand.
 Assumes the package, design and host model are compiled before it.
*/
`timescale 1ns/10ps
module uart_compatible_register_map_tb_top;
    import ucrm_pkg::*;

    // ==========================================================
    // Signals
    typedef struct packed {
        logic wr;
        logic [2:0] addr;
        logic [7:0] val;
        logic enh;
        logic swap;
        logic [7:0] exp;
    } ucrm_row_t;

    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    ucrm_bus_t bus;
    logic [7:0] data_o;
    logic data_oe_o;
    logic foreign_o;
    logic enh_en_i = 1'b0;
    logic swap_spad_i = 1'b0;
    logic [7:0] rx_data_i = 8'h3c;
    logic rx_pop_o;
    logic [7:0] tx_data_o;
    logic tx_push_o;
    logic rx_fifo_rst_o;
    logic tx_fifo_rst_o;
    ucrm_sts_t sts_i = '{4'h6, 1'b1, 1'b1, 8'h61, 8'h9e};
    logic lsts_read_o;
    logic ists_read_o;
    logic [MODEM_CNT-1:0] modem_in_i = 4'ha;
    logic dtr_o;
    logic rts_o;
    logic out1_o;
    logic irq_en_o;
    ucrm_ctl_t ctl_o;
    int error_cnt = 0;
    int checked = 0;
    int pop_n = 0;
    int push_n = 0;
    int rxr_n = 0;
    int txr_n = 0;
    int lrd_n = 0;
    int ird_n = 0;
    int fgn_n = 0;
    logic [7:0] q;
    logic oe;

    ucrm_row_t rows [17] = '{
        '{1'b1, ADR_IEN, 8'hff, 1'b0, 1'b0, 8'h00},
        '{1'b0, ADR_IEN, 8'h00, 1'b0, 1'b0, 8'h0f},
        '{1'b1, ADR_IEN, 8'hff, 1'b1, 1'b0, 8'h00},
        '{1'b0, ADR_IEN, 8'h00, 1'b1, 1'b0, 8'hff},
        '{1'b0, ADR_IEN, 8'h00, 1'b0, 1'b0, 8'h0f},
        '{1'b1, ADR_LCTL, 8'h5a, 1'b0, 1'b0, 8'h00},
        '{1'b0, ADR_LCTL, 8'h00, 1'b0, 1'b0, 8'h5a},
        '{1'b1, ADR_MCTL, 8'hef, 1'b0, 1'b0, 8'h00},
        '{1'b0, ADR_MCTL, 8'h00, 1'b0, 1'b0, 8'h0f},
        '{1'b1, ADR_MCTL, 8'hef, 1'b1, 1'b0, 8'h00},
        '{1'b0, ADR_MCTL, 8'h00, 1'b1, 1'b0, 8'hef},
        '{1'b1, ADR_SPAD, 8'ha5, 1'b0, 1'b0, 8'h00},
        '{1'b0, ADR_SPAD, 8'h00, 1'b0, 1'b0, 8'ha5},
        '{1'b0, ADR_LSTS, 8'h00, 1'b0, 1'b0, 8'h61},
        '{1'b0, ADR_ISTS, 8'h00, 1'b0, 1'b0, 8'h06},
        '{1'b0, ADR_ISTS, 8'h00, 1'b1, 1'b0, 8'h36},
        '{1'b0, ADR_MSTS, 8'h00, 1'b0, 1'b0, 8'ha0}
    };

    // ==========================================================
    // Clock, instances and pulse counters
    always #4 clk_sys_i = ~clk_sys_i;

    ucrm_host_model u_ucrm_host_model (
        .clk_sys_i(clk_sys_i), .bus_o(bus), .data_i(data_o), .data_oe_i(data_oe_o)
    );

    ucrm_regmap u_ucrm_regmap (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .bus_i(bus),
        .data_o(data_o), .data_oe_o(data_oe_o), .foreign_o(foreign_o),
        .enh_en_i(enh_en_i), .swap_spad_i(swap_spad_i), .rx_data_i(rx_data_i),
        .rx_pop_o(rx_pop_o), .tx_data_o(tx_data_o), .tx_push_o(tx_push_o),
        .rx_fifo_rst_o(rx_fifo_rst_o), .tx_fifo_rst_o(tx_fifo_rst_o), .sts_i(sts_i),
        .lsts_read_o(lsts_read_o), .ists_read_o(ists_read_o), .modem_in_i(modem_in_i),
        .dtr_o(dtr_o), .rts_o(rts_o), .out1_o(out1_o), .irq_en_o(irq_en_o), .ctl_o(ctl_o)
    );

    always @(negedge clk_sys_i) begin
        pop_n += (rx_pop_o === 1'b1);
        push_n += (tx_push_o === 1'b1);
        rxr_n += (rx_fifo_rst_o === 1'b1);
        txr_n += (tx_fifo_rst_o === 1'b1);
        lrd_n += (lsts_read_o === 1'b1);
        ird_n += (ists_read_o === 1'b1);
    end

    // Bus strobes change only at falling edges, so each access is seen twice here.
    always @(posedge clk_sys_i) begin
        fgn_n += (foreign_o === 1'b1);
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_ucrm_host_model.access(1'b1, a, d, q, oe);
    endtask

    // A refused read only checks that the bus is left undriven.
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic exp_oe);
        u_ucrm_host_model.access(1'b0, a, 8'h00, q, oe);
        if (exp_oe) chk(q, exp);
        chk({7'h00, oe}, {7'h00, exp_oe});
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (6) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        chk({7'h00, |ctl_o}, 8'h00);
        chk({dtr_o, rts_o, out1_o, irq_en_o, data_oe_o, tx_push_o, rx_pop_o, foreign_o}, 8'h00);
        foreach (rows[i]) begin
            enh_en_i = rows[i].enh;
            swap_spad_i = rows[i].swap;
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].val);
            end else begin
                rd(rows[i].addr, rows[i].exp, 1'b1);
            end
        end
        chk({4'h0, dtr_o, rts_o, out1_o, irq_en_o}, 8'h0f);
        modem_in_i = 4'h5;
        repeat (2) @(negedge clk_sys_i);
        rd(ADR_MSTS, 8'h5f, 1'b1);
        rd(ADR_MSTS, 8'h50, 1'b1);
        wr(ADR_MCTL, 8'h13);
        chk({4'h0, dtr_o, rts_o, out1_o, irq_en_o}, 8'h00);
        rd(ADR_MSTS, 8'h36, 1'b1);
        wr(ADR_MCTL, 8'h00);
        wr(ADR_HOLD, 8'h5a);
        chk(tx_data_o, 8'h5a);
        rd(ADR_HOLD, 8'h3c, 1'b1);
        chk(8'(push_n * 16 + pop_n), 8'h11);
        wr(ADR_ISTS, 8'hff);
        chk(ctl_o.fctl, 8'hc1);
        rd(ADR_ISTS, 8'hc6, 1'b1);
        enh_en_i = 1'b1;
        wr(ADR_ISTS, 8'hff);
        chk(ctl_o.fctl, 8'hf9);
        chk(8'(rxr_n * 16 + txr_n), 8'h22);
        chk(8'(lrd_n * 16 + ird_n), 8'h13);
        wr(ADR_MSTS, 8'hff);
        chk(ctl_o.opts, 8'hf0);
        swap_spad_i = 1'b1;
        wr(ADR_SPAD, 8'hff);
        chk(ctl_o.ems, 8'hcf);
        rd(ADR_SPAD, 8'h9e, 1'b1);
        swap_spad_i = 1'b0;
        rd(ADR_SPAD, 8'ha5, 1'b1);
        wr(ADR_LCTL, 8'h80);
        wr(ADR_IEN, 8'h00);
        rd(ADR_HOLD, 8'h00, 1'b0);
        wr(ADR_LCTL, LCTL_ENH_KEY);
        rd(ADR_LSTS, 8'h00, 1'b0);
        wr(ADR_LCTL, 8'h00);
        rd(ADR_IEN, 8'hff, 1'b1);
        chk(8'(pop_n * 16 + lrd_n), 8'h11);
        chk(8'(fgn_n), 8'h06);
        // A write made while the clock enable is low must leave no trace.
        ce_i = 1'b0;
        wr(ADR_SPAD, 8'h11);
        ce_i = 1'b1;
        rd(ADR_SPAD, 8'ha5, 1'b1);
        // A reset in mid-run clears every register at once.
        rstn_i = 1'b0;
        @(negedge clk_sys_i);
        chk({7'h00, |ctl_o}, 8'h00);
        chk({dtr_o, rts_o, out1_o, irq_en_o, data_oe_o, tx_push_o, rx_pop_o, foreign_o}, 8'h00);
        rstn_i = 1'b1;
        rd(ADR_IEN, 8'h00, 1'b1);
        conclude();
    end
endmodule
